// file: lps_pkg.sv
`default_nettype none
package lps_pkg;
   localparam int         TW          = 16;
   localparam int         AW          = 8;
   // Register byte addresses.
   localparam logic [7:0] ADR_CTRL    = 8'h00;
   localparam logic [7:0] ADR_STAT    = 8'h04;
   localparam logic [7:0] ADR_OVT     = 8'h08;
   localparam logic [7:0] ADR_UVT     = 8'h0c;
   localparam logic [7:0] ADR_OCT     = 8'h10;
   localparam logic [7:0] ADR_OPT     = 8'h14;
   // Control register fields; bits 4..0 are self-clearing commands.
   localparam int         CB_START    = 0;
   localparam int         CB_CLEAR    = 1;
   localparam int         CB_STOP     = 2;
   localparam int         CB_LOCK     = 3;
   localparam int         CB_UNLOCK   = 4;
   localparam int         CB_MODE     = 8;
   localparam int         CB_ILK_EN   = 10;
   // Status register fields.
   localparam int         ST_OP       = 0;
   localparam int         ST_REG      = 4;
   localparam int         ST_ALM      = 8;
   localparam int         ST_LOCK     = 16;
   // Control modes and regulation loop codes share one encoding.
   localparam logic [1:0] MODE_VOLT   = 2'h0;
   localparam logic [1:0] MODE_CURR   = 2'h1;
   localparam logic [1:0] MODE_PWR    = 2'h2;
   localparam logic [1:0] MODE_RES    = 2'h3;
   localparam logic [1:0] MODE_RST    = MODE_VOLT;
   // Threshold selectors.
   localparam logic [1:0] THR_OV      = 2'h0;
   localparam logic [1:0] THR_UV      = 2'h1;
   localparam logic [1:0] THR_OC      = 2'h2;
   localparam logic [1:0] THR_OP      = 2'h3;
   // Alarm bit positions.
   localparam int         AL_OV       = 0;
   localparam int         AL_UV       = 1;
   localparam int         AL_OC       = 2;
   localparam int         AL_OP       = 3;
   localparam int         AL_IO       = 4;
   localparam int         AL_ILK      = 5;
   localparam int         NALM        = 6;
   localparam int         NIO         = 8;
   // Percentages of full scale.
   localparam int         PCT_MAX     = 110;
   localparam int         PCT_UV_MIN  = 5;
   localparam int         PCT_DIV     = 100;
   typedef enum logic [1:0] {OP_DISABLED, OP_ENABLED, OP_SOFT, OP_HARD} lps_op_t;
endpackage : lps_pkg
`default_nettype wire

// file: lps_trip_qual.sv
`timescale 1ns/10ps
`default_nettype none
module lps_trip_qual #(
   parameter int N = 4
) (
   input  wire logic clk_sys_i,
   input  wire logic reset_i,
   input  wire logic arm_i,
   input  wire logic sample_i,
   input  wire logic over_i,
   output logic      trip_o
);
   import lps_pkg::*;
   localparam int          CW   = $clog2(N + 1);
   localparam logic [CW-1:0] LAST = CW'(N - 1);
   logic [CW-1:0] cnt;

   // Counts consecutive out-of-limit samples; any in-limit sample restarts.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !arm_i) begin
         cnt    <= '0;
         trip_o <= 1'b0;
      end else if (sample_i) begin
         if (!over_i) begin
            cnt    <= '0;
            trip_o <= 1'b0;
         end else if (!trip_o) begin
            cnt    <= cnt + 1'b1;
            trip_o <= (cnt == LAST);
         end
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   property p_trip_needs_run;
      $rose(trip_o) |-> $past(sample_i) && $past(over_i) && $past(cnt) == LAST;
   endproperty
   a_trip_needs_run: assert property (p_trip_needs_run)
      else $error("Trip registered without a full run of samples.");
   property p_inlimit_resets;
      sample_i && !over_i && arm_i |=> cnt == '0 && !trip_o;
   endproperty
   a_inlimit_resets: assert property (p_inlimit_resets)
      else $error("In-limit sample did not reset the count.");
   c_trip: cover property ($rose(trip_o));
endmodule : lps_trip_qual
`default_nettype wire

// file: lps_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
module lps_supervisor #(
   parameter int V_FS         = 50000,
   parameter int I_FS         = 50000,
   parameter int P_FS         = 50000,
   parameter int TRIP_SAMPLES = 4
) (
   input  wire logic                    clk_sys_i,
   input  wire logic                    reset_i,
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [lps_pkg::AW-1:0]  wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   input  wire logic                    meas_valid_i,
   input  wire logic [lps_pkg::TW-1:0]  meas_volt_i,
   input  wire logic [lps_pkg::TW-1:0]  meas_curr_i,
   input  wire logic [lps_pkg::TW-1:0]  meas_pwr_i,
   input  wire logic [1:0]              reg_loop_i,
   input  wire logic                    thermal_i,
   input  wire logic                    interlock_i,
   input  wire logic                    dig_lock_i,
   input  wire logic [lps_pkg::NIO-1:0] io_over_i,
   input  wire logic                    panel_start_i,
   input  wire logic                    panel_clear_i,
   input  wire logic                    panel_stop_i,
   input  wire logic                    panel_lock_i,
   input  wire logic                    ext_thr_we_i,
   input  wire logic                    ext_thr_panel_i,
   input  wire logic [1:0]              ext_thr_sel_i,
   input  wire logic [lps_pkg::TW-1:0]  ext_thr_val_i,
   output logic                         input_engage_o,
   output logic [1:0]                   op_state_o,
   output logic                         hard_fault_o,
   output logic [lps_pkg::NALM-1:0]     alarm_o,
   output logic [3:0]                   reg_led_o,
   output logic                         lock_led_o
);
   import lps_pkg::*;
   localparam logic [TW-1:0] OV_MAX = TW'((V_FS * PCT_MAX) / PCT_DIV);
   localparam logic [TW-1:0] UV_MIN = TW'((V_FS * PCT_UV_MIN + PCT_DIV - 1) / PCT_DIV);
   localparam logic [TW-1:0] OC_MAX = TW'((I_FS * PCT_MAX) / PCT_DIV);
   localparam logic [TW-1:0] OP_MAX = TW'((P_FS * PCT_MAX) / PCT_DIV);
   localparam int            NP     = NIO + 3;

   function automatic logic [3:0] onehot(input logic [1:0] c);
      onehot = 4'h1 << c;
   endfunction : onehot

   function automatic logic [TW-1:0] clamp_thr(input logic [1:0] s, input logic [TW-1:0] v);
      logic [TW-1:0] r;
      r = v;
      unique case (s)
         THR_OV: if (v > OV_MAX) r = OV_MAX;
         THR_UV: if (v != '0 && v < UV_MIN) r = UV_MIN;
         THR_OC: if (v > OC_MAX) r = OC_MAX;
         THR_OP: if (v > OP_MAX) r = OP_MAX;
      endcase
      return r;
   endfunction : clamp_thr

   function automatic logic [TW-1:0] merge16(input logic [TW-1:0] o, input logic [31:0] d,
                                             input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
   endfunction : merge16

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   // Pin inputs: three-stage synchroniser, a change counts when stages two and three agree.
   logic [NP-1:0] pin_s1;
   logic [NP-1:0] pin_s2;
   logic [NP-1:0] pin_s3;
   logic [NP-1:0] pin_f;
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_s3 <= '0;
         pin_f  <= '0;
      end else begin
         pin_s1 <= {io_over_i, dig_lock_i, interlock_i, thermal_i};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_f  <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
      end
   end
   logic therm_f;
   logic ilk_f;
   logic dlock_f;
   logic io_f;
   assign therm_f = pin_f[0];
   assign ilk_f   = pin_f[1];
   assign dlock_f = pin_f[2];
   assign io_f    = |pin_f[NP-1:3];

   // Wishbone slave: ack one cycle after the request, writes act on the ack edge.
   logic wb_req;
   logic wb_wr;
   logic ctl_wr;
   assign wb_req = wb_cyc_i && wb_stb_i;
   assign wb_wr  = wb_req && wb_we_i && wb_ack_o;
   assign ctl_wr = wb_wr && wb_adr_i == ADR_CTRL;
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) wb_ack_o <= 1'b0;
      else wb_ack_o <= wb_req && !wb_ack_o;
   end

   // Host control register and commands.
   logic [1:0] mode;
   logic       ilk_en;
   logic [1:0] next_mode;
   logic       h_start;
   logic       h_clear;
   logic       h_stop;
   logic       h_lock;
   logic       h_unlock;
   logic       mode_chg;
   assign next_mode = wb_dat_i[CB_MODE +: 2];
   assign h_start   = ctl_wr && wb_sel_i[0] && wb_dat_i[CB_START];
   assign h_clear   = ctl_wr && wb_sel_i[0] && wb_dat_i[CB_CLEAR];
   assign h_stop    = ctl_wr && wb_sel_i[0] && wb_dat_i[CB_STOP];
   assign h_lock    = ctl_wr && wb_sel_i[0] && wb_dat_i[CB_LOCK];
   assign h_unlock  = ctl_wr && wb_sel_i[0] && wb_dat_i[CB_UNLOCK];
   assign mode_chg  = ctl_wr && wb_sel_i[1] && next_mode != mode;
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         mode   <= MODE_RST;
         ilk_en <= 1'b0;
      end else if (ctl_wr && wb_sel_i[1]) begin
         mode   <= next_mode;
         ilk_en <= wb_dat_i[CB_ILK_EN];
      end
   end

   // Lock sources and their ranking.
   logic lock_host;
   logic lock_panel;
   logic locked;
   assign locked = dlock_f || lock_host || lock_panel;
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         lock_host  <= 1'b0;
         lock_panel <= 1'b0;
      end else begin
         if (h_lock) lock_host <= 1'b1;
         else if (h_unlock && !dlock_f) lock_host <= 1'b0;
         if (h_unlock && !dlock_f) lock_panel <= 1'b0;
         else if (panel_lock_i && !dlock_f && !lock_host) lock_panel <= !lock_panel;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) lock_led_o <= 1'b0;
      else lock_led_o <= locked;
   end

   // Trip thresholds; the bus wins over the external port in the same cycle.
   logic [TW-1:0] thr [4];
   logic          panel_thr_ok;
   assign panel_thr_ok = ext_thr_we_i && !(ext_thr_panel_i && locked);
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         thr[THR_OV] <= OV_MAX;
         thr[THR_UV] <= '0;
         thr[THR_OC] <= OC_MAX;
         thr[THR_OP] <= OP_MAX;
      end else begin
         if (panel_thr_ok) thr[ext_thr_sel_i] <= clamp_thr(ext_thr_sel_i, ext_thr_val_i);
         for (int i = 0; i < 4; i++) begin
            if (wb_wr && wb_adr_i == ADR_OVT + AW'(4 * i))
               thr[i] <= clamp_thr(2'(i), merge16(thr[i], wb_dat_i, wb_sel_i));
         end
      end
   end

   // Trip qualification against the thresholds.
   lps_op_t       op;
   logic [3:0]    over;
   logic [3:0]    arm;
   logic [3:0]    trip;
   logic          uv_on;
   assign uv_on   = thr[THR_UV] != '0;
   assign over[THR_OV] = meas_volt_i > thr[THR_OV];
   assign over[THR_UV] = uv_on && meas_volt_i <= thr[THR_UV];
   assign over[THR_OC] = meas_curr_i > thr[THR_OC];
   assign over[THR_OP] = meas_pwr_i > thr[THR_OP];
   assign arm = {1'b1, 1'b1, op == OP_ENABLED, 1'b1};
   for (genvar g = 0; g < 4; g++) begin : g_qual
      lps_trip_qual #(.N(TRIP_SAMPLES)) u_qual (
         .clk_sys_i (clk_sys_i),
         .reset_i   (reset_i),
         .arm_i     (arm[g]),
         .sample_i  (meas_valid_i),
         .over_i    (over[g]),
         .trip_o    (trip[g])
      );
   end

   // Commands from host and panel; a locked panel keeps its stop button but loses start and clear.
   logic start_cmd;
   logic clear_cmd;
   logic stop_cmd;
   assign start_cmd = h_start || (panel_start_i && !locked);
   assign clear_cmd = h_clear || (panel_clear_i && !locked);
   assign stop_cmd  = h_stop || panel_stop_i;

   // Last taken sample; the bus carries no meaning between valid pulses.
   logic [TW-1:0] smp_volt;
   logic [TW-1:0] smp_curr;
   logic [TW-1:0] smp_pwr;
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         smp_volt <= '0;
         smp_curr <= '0;
         smp_pwr  <= '0;
      end else if (meas_valid_i) begin
         smp_volt <= meas_volt_i;
         smp_curr <= meas_curr_i;
         smp_pwr  <= meas_pwr_i;
      end
   end

   // Fault events and recovery conditions.
   logic [NALM-1:0] evt;
   logic            uv_inst;
   logic            recovered;
   logic            clear_ok;
   logic            ilk_lost;
   assign ilk_lost  = ilk_en && !ilk_f;
   assign uv_inst   = op == OP_DISABLED && start_cmd && uv_on &&
                      smp_volt <= thr[THR_UV];
   assign evt[AL_OV]  = trip[THR_OV];
   assign evt[AL_UV]  = trip[THR_UV] || uv_inst;
   assign evt[AL_OC]  = trip[THR_OC];
   assign evt[AL_OP]  = trip[THR_OP];
   assign evt[AL_IO]  = io_f;
   assign evt[AL_ILK] = ilk_lost;
   assign recovered = smp_volt < thr[THR_OV] &&
                      smp_curr < thr[THR_OC] &&
                      smp_pwr < thr[THR_OP] &&
                      !io_f &&
                      !ilk_lost;
   assign clear_ok  = op == OP_SOFT && clear_cmd && recovered && !therm_f;

   // Operating state.
   lps_op_t next_op;
   always_comb begin
      next_op = op;
      unique case (op)
         OP_HARD:     next_op = OP_HARD;
         OP_ENABLED:  if (stop_cmd || mode_chg) next_op = OP_DISABLED;
         OP_DISABLED: if (start_cmd && !locked_out()) next_op = OP_ENABLED;
         OP_SOFT:     if (clear_ok) next_op = OP_DISABLED;
      endcase
      if (op != OP_HARD && |evt) next_op = OP_SOFT;
      if (therm_f) next_op = OP_HARD;
   end

   function automatic logic locked_out();
      return therm_f;
   endfunction : locked_out

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         op             <= OP_DISABLED;
         input_engage_o <= 1'b0;
         hard_fault_o   <= 1'b0;
         op_state_o     <= 2'(OP_DISABLED);
      end else begin
         op             <= next_op;
         input_engage_o <= next_op == OP_ENABLED;
         hard_fault_o   <= next_op == OP_HARD;
         op_state_o     <= 2'(next_op);
      end
   end

   // Sticky alarms: a new event wins over a Clear in the same cycle.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) alarm_o <= '0;
      else if (op != OP_HARD) alarm_o <= (clear_ok ? '0 : alarm_o) | evt;
   end

   // Regulation state indicator.
   logic [1:0] reg_code;
   always_comb begin
      reg_code = reg_loop_i;
      if (reg_loop_i == MODE_RES && mode != MODE_RES) reg_code = mode;
   end
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) reg_led_o <= onehot(MODE_RST);
      else reg_led_o <= onehot(reg_code);
   end

   // Register read data.
   logic [31:0] rdat;
   always_comb begin
      rdat = '0;
      unique case (wb_adr_i)
         ADR_CTRL: begin
            rdat[CB_MODE +: 2] = mode;
            rdat[CB_ILK_EN]    = ilk_en;
         end
         ADR_STAT: begin
            rdat[ST_OP +: 2]    = op_state_o;
            rdat[ST_REG +: 4]   = reg_led_o;
            rdat[ST_ALM +: NALM] = alarm_o;
            rdat[ST_LOCK +: 3]  = {dlock_f, lock_host, lock_panel};
         end
         ADR_OVT: rdat[TW-1:0] = thr[THR_OV];
         ADR_UVT: rdat[TW-1:0] = thr[THR_UV];
         ADR_OCT: rdat[TW-1:0] = thr[THR_OC];
         ADR_OPT: rdat[TW-1:0] = thr[THR_OP];
         default: rdat = '0;
      endcase
   end
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) wb_dat_o <= '0;
      else if (wb_req && !wb_ack_o && !wb_we_i) wb_dat_o <= rdat;
   end

   // Checks.
   property p_reg_onehot;
      $onehot(reg_led_o);
   endproperty
   a_reg_onehot: assert property (p_reg_onehot)
      else $error("Regulation indicator not one-hot.");
   property p_no_cr;
      $past(mode) != MODE_RES |-> !reg_led_o[MODE_RES];
   endproperty
   a_no_cr: assert property (p_no_cr)
      else $error("Resistance state shown outside resistance mode.");
   property p_limits;
      thr[THR_OV] <= OV_MAX && thr[THR_OC] <= OC_MAX && thr[THR_OP] <= OP_MAX;
   endproperty
   a_limits: assert property (p_limits)
      else $error("Upper trip limit above 110 percent.");
   property p_uv_min;
      thr[THR_UV] == '0 || thr[THR_UV] >= UV_MIN;
   endproperty
   a_uv_min: assert property (p_uv_min)
      else $error("Under-voltage limit below minimum.");
   property p_alarm_opens;
      |evt && op != OP_HARD && !therm_f |=>
         !input_engage_o && op == OP_SOFT && (alarm_o & $past(evt)) != '0;
   endproperty
   a_alarm_opens: assert property (p_alarm_opens)
      else $error("Fault did not open the input.");
   property p_uv_inst;
      uv_inst && !therm_f |=> op == OP_SOFT && alarm_o[AL_UV];
   endproperty
   a_uv_inst: assert property (p_uv_inst)
      else $error("Start below under-voltage limit did not trip.");
   property p_hard_sticky;
      op == OP_HARD |=> op == OP_HARD && hard_fault_o && !input_engage_o [*3];
   endproperty
   a_hard_sticky: assert property (p_hard_sticky)
      else $error("Hard fault left without reset.");
   property p_ilk;
      ilk_lost && op == OP_ENABLED && !therm_f |=> op == OP_SOFT ##0 !input_engage_o;
   endproperty
   a_ilk: assert property (p_ilk)
      else $error("Interlock loss did not fault.");
   property p_clear;
      clear_ok && evt == '0 |=> op == OP_DISABLED && alarm_o == '0;
   endproperty
   a_clear: assert property (p_clear)
      else $error("Clear did not return to disabled.");
   property p_start;
      op == OP_DISABLED && start_cmd && evt == '0 && !therm_f |=> input_engage_o;
   endproperty
   a_start: assert property (p_start)
      else $error("Start did not engage the input.");
   property p_mode_chg;
      op == OP_ENABLED && mode_chg |=> !input_engage_o;
   endproperty
   a_mode_chg: assert property (p_mode_chg)
      else $error("Mode change left input engaged.");
   property p_dig_lock;
      dlock_f |=> lock_led_o;
   endproperty
   a_dig_lock: assert property (p_dig_lock)
      else $error("Lock lamp dark while locked.");
   c_soft:  cover property (op == OP_ENABLED ##1 op == OP_SOFT);
   c_rec:   cover property (op == OP_SOFT ##1 op == OP_DISABLED ##[1:50] op == OP_ENABLED);
   c_hard:  cover property (op == OP_SOFT ##1 op == OP_HARD);
   c_lock:  cover property (lock_panel && h_unlock);
endmodule : lps_supervisor
`default_nettype wire

// file: lps_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module lps_src_model (
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   input  wire logic [15:0] volt_i,
   input  wire logic [15:0] curr_i,
   input  wire logic [15:0] pwr_i,
   output logic             meas_valid_o,
   output logic [15:0]      meas_volt_o,
   output logic [15:0]      meas_curr_o,
   output logic [15:0]      meas_pwr_o
);
   logic [1:0] div;
   // A sample every third cycle; between samples the values are scrambled.
   always_ff @(posedge clk_sys_i) begin
      div          <= (reset_i || div == 2'h2) ? 2'h0 : div + 2'h1;
      meas_valid_o <= !reset_i && div == 2'h2;
      meas_volt_o  <= (div == 2'h2) ? volt_i : ~meas_volt_o;
      meas_curr_o  <= (div == 2'h2) ? curr_i : ~meas_curr_o;
      meas_pwr_o   <= (div == 2'h2) ? pwr_i : ~meas_pwr_o;
   end
endmodule : lps_src_model
`default_nettype wire

// file: test_load_protection_fault_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
module test_load_protection_fault_supervisor;
   import lps_pkg::*;
   localparam int MX = 50000 * PCT_MAX / PCT_DIV;
   logic        clk_sys_i, reset_i, cyc, we, ack, mv, eng, hard, lled, xwe;
   logic [7:0]  adr, io;
   logic [31:0] wd, rdat, q, ctl;
   logic [15:0] mvo, mc, mp, t[3], xval;
   logic [1:0]  ops, loop;
   logic [5:0]  alm;
   logic [3:0]  led, pb, pin;
   int          failures, num_checks, k;
   lps_src_model lps_src_model_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .volt_i(t[0]),
      .curr_i(t[1]), .pwr_i(t[2]), .meas_valid_o(mv), .meas_volt_o(mvo), .meas_curr_o(mc),
      .meas_pwr_o(mp));
   lps_supervisor #(.TRIP_SAMPLES(2)) lps_supervisor_i (.clk_sys_i(clk_sys_i),
      .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .meas_valid_i(mv),
      .meas_volt_i(mvo), .meas_curr_i(mc), .meas_pwr_i(mp), .reg_loop_i(loop),
      .thermal_i(pin[0]), .interlock_i(pin[1]), .dig_lock_i(pin[2]), .io_over_i(io),
      .panel_start_i(pb[0]), .panel_clear_i(pb[1]), .panel_stop_i(pb[2]),
      .panel_lock_i(pb[3]), .ext_thr_we_i(xwe), .ext_thr_panel_i(1'b0),
      .ext_thr_sel_i(THR_OC), .ext_thr_val_i(xval), .input_engage_o(eng),
      .op_state_o(ops), .hard_fault_o(hard), .alarm_o(alm), .reg_led_o(led),
      .lock_led_o(lled));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic chk_st(input logic [1:0] o, input int a);
      num_checks++;
      if ({ops, eng, alm} !== {o, o == OP_ENABLED, 6'(1 << a) & 6'h3e | 6'(a == 0)}) begin
         failures++;
         $display("wrong value at %0t: state %h alarms %h", $time, ops, alm);
      end
   endtask : chk_st
   task automatic tk(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : tk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      {cyc, we, adr, wd} <= {1'b1, w, a, d};
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0;
      if (n >= 50) begin
         failures++;
         tally_and_finish();
      end
   endtask : wb
   task automatic cmd(input int b);
      wb(1'b1, ADR_CTRL, ctl | (32'h1 << b));
      tk(2);
   endtask : cmd
   task automatic pan(input int b);
      @(posedge clk_sys_i);
      pb[b] <= 1'b1;
      @(posedge clk_sys_i);
      pb <= 4'h0;
      tk(2);
   endtask : pan
   initial begin
      clk_sys_i = 0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      tk(20000);
      failures++;
      tally_and_finish();
   end
   initial begin
      {failures, num_checks, cyc, we, adr, wd, loop, pin, io, pb, xwe, xval, ctl} = '0;
      t = '{16'd1000, 16'd1000, 16'd1000};
      reset_i = 1;
      void'($urandom(14733));
      tk(3);
      reset_i <= 0;
      tk(6);
      chk_st(OP_DISABLED, -1);
      wb(0, ADR_OVT, 0); chk(q, MX);
      wb(0, ADR_UVT, 0); chk(q, 0);
      wb(0, ADR_OPT, 0); chk(q, MX);
      wb(0, 8'h40, 0); chk(q, 0);
      wb(1, ADR_OVT, 32'hffff); wb(0, ADR_OVT, 0); chk(q, MX);
      wb(1, ADR_UVT, 1); wb(0, ADR_UVT, 0); chk(q, (50000 * PCT_UV_MIN + 99) / PCT_DIV);
      wb(1, ADR_UVT, 0);
      $display("test limits done");
      cmd(CB_START); chk_st(OP_ENABLED, -1);
      t[0] <= MX + 1; tk(3); t[0] <= 1000; tk(9); chk_st(OP_ENABLED, -1);
      for (k = 0; k < 3; k++) begin
         t[k] <= 16'($urandom_range(65535, MX + 1)); tk(12);
         chk_st(OP_SOFT, k == 0 ? AL_OV : k + 1);
         cmd(CB_CLEAR); chk_st(OP_SOFT, k == 0 ? AL_OV : k + 1);
         t[k] <= 1000; tk(6); cmd(CB_CLEAR); chk_st(OP_DISABLED, -1);
         cmd(CB_START); chk_st(OP_ENABLED, -1);
      end
      cmd(CB_STOP); wb(1, ADR_UVT, 3000); t[0] <= 2000; tk(6);
      cmd(CB_START); chk_st(OP_SOFT, AL_UV);
      pan(1); chk_st(OP_DISABLED, -1);
      wb(1, ADR_UVT, 0);
      for (k = 0; k < 4; k++) begin
         ctl = 32'(k) << CB_MODE; wb(1, ADR_CTRL, ctl); loop <= 2'(k); tk(2);
         chk(led, 32'h1 << k); loop <= MODE_RES; tk(2);
         chk(led, 32'h1 << k);
      end
      cmd(CB_START); ctl = 0; wb(1, ADR_CTRL, ctl); tk(2); chk_st(OP_DISABLED, -1);
      $display("test trips and modes done");
      cmd(CB_LOCK); pan(0); chk({lled, ops}, {1'b1, OP_DISABLED});
      pin[2] <= 1; tk(6); cmd(CB_UNLOCK); pin[2] <= 0; tk(6); chk(lled, 1);
      cmd(CB_UNLOCK); chk(lled, 0); pan(3); chk(lled, 1);
      cmd(CB_START); pan(2); chk_st(OP_DISABLED, -1);
      cmd(CB_UNLOCK); chk(lled, 0);
      @(posedge clk_sys_i) {xwe, xval} <= {1'b1, 16'd30000};
      @(posedge clk_sys_i) xwe <= 0;
      wb(0, ADR_OCT, 0); chk(q, 30000);
      io <= 8'h80; tk(7); cmd(CB_CLEAR); chk_st(OP_SOFT, AL_IO);
      io <= 0; tk(6); cmd(CB_CLEAR); chk_st(OP_DISABLED, -1);
      ctl[CB_ILK_EN] = 1; wb(1, ADR_CTRL, ctl); tk(7); chk_st(OP_SOFT, AL_ILK);
      cmd(CB_CLEAR); chk_st(OP_SOFT, AL_ILK);
      pin[1] <= 1; tk(6); cmd(CB_CLEAR); chk_st(OP_DISABLED, -1);
      pin[0] <= 1; tk(7); chk({hard, eng, ops}, {2'b10, OP_HARD});
      cmd(CB_CLEAR); cmd(CB_START); chk({hard, eng, ops}, {2'b10, OP_HARD});
      $display("test locks and faults done");
      tally_and_finish();
   end
endmodule : test_load_protection_fault_supervisor
`default_nettype wire
